// ===== logic/slc_pkg.sv
// Shared constants and types of the softload command engine
package slc_pkg;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int unsigned CLK_HZ         = 10_000_000;
  localparam int unsigned START_WAIT_S   = 120;
  localparam int unsigned START_WAIT_CYC = START_WAIT_S * CLK_HZ;
  localparam int unsigned REINIT_S       = 10;
  localparam int unsigned REINIT_CYC     = REINIT_S * CLK_HZ;
  localparam int unsigned G_GAP_MS       = 1000;
  localparam int unsigned G_GAP_CYC      = G_GAP_MS * (CLK_HZ / 1000);
  localparam int unsigned TMR_W          = 31;
  localparam int unsigned GAP_W          = 24;

  // ----------------------------------------------------------------
  // Stream bytes and counts
  // ----------------------------------------------------------------
  localparam logic [7:0]  CAN_BYTE     = 8'h18;
  localparam logic [7:0]  G_BYTE       = 8'h47;
  localparam logic [3:0]  CAN_SERIES   = 4'h8;
  localparam logic [1:0]  HOST_CAN_MIN = 2'h2;

  // ----------------------------------------------------------------
  // Result codes
  // ----------------------------------------------------------------
  localparam logic [7:0] RES_NONE       = 8'h00;
  localparam logic [7:0] RES_DONE       = 8'h10;
  localparam logic [7:0] RES_BAD_PW     = 8'h80;
  localparam logic [7:0] RES_START_TO   = 8'hc1;
  localparam logic [7:0] RES_CAN_RX     = 8'hc8;
  localparam logic [7:0] RES_ALT_BAD    = 8'h74;
  localparam logic [7:0] RES_OTHER_PORT = 8'h79;
  localparam logic [7:0] RES_COPY_FAIL  = 8'h7a;

  // ----------------------------------------------------------------
  // Enumerations
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {CMD_QUERY, CMD_DOWNLOAD, CMD_COPY, CMD_SWAP} slc_cmd_t;
  typedef enum logic [2:0] {MSG_OK, MSG_ERROR, MSG_READY, MSG_BANNER, MSG_VERSION} slc_msg_t;
  typedef enum logic [2:0] {FOP_NONE, FOP_ERASE, FOP_COPY, FOP_VERIFY, FOP_CHECK} slc_fop_t;
  typedef enum logic [3:0] {
    ST_IDLE, ST_DL_ERASE, ST_DL_WAIT_G, ST_DL_XFER, ST_DL_VERIFY, ST_DL_CANCEL,
    ST_CP_ERASE, ST_CP_PROG, ST_CP_VERIFY, ST_SW_CHECK, ST_SW_REINIT
  } slc_state_t;

endpackage

// ===== logic/slc_timer.sv
// Loadable down-counter that pulses once on expiry
module slc_timer #(
  parameter int unsigned WIDTH = 31
) (
  input  wire logic             clock_in,
  input  wire logic             rst_in,
  input  wire logic             clk_en_in,
  input  wire logic             load_in,
  input  wire logic             stop_in,
  input  wire logic [WIDTH-1:0] value_in,
  output logic                  expired_out
);

  typedef struct packed {
    logic             run;
    logic [WIDTH-1:0] cnt;
    logic             expired;
  } slc_tmr_t;

  slc_tmr_t s;
  slc_tmr_t n;

  if (WIDTH < 2 || WIDTH > 32) begin : g_bad_width
    $error("slc_timer: WIDTH out of range");
  end

  always_comb begin
    n = s;
    n.expired = 1'b0;
    if (load_in) begin
      n.run = (value_in != '0);
      n.cnt = value_in;
    end else if (stop_in) begin
      n.run = 1'b0;
    end else if (s.run) begin
      if (s.cnt <= WIDTH'(1)) begin
        n.run = 1'b0;
        n.expired = 1'b1;
      end
      n.cnt = s.cnt - WIDTH'(1);
    end
  end

  always_ff @(posedge clock_in or posedge rst_in) begin
    if (rst_in) begin
      s <= '0;
    end else if (clk_en_in) begin
      s <= n;
    end
  end

  assign expired_out = s.expired;

endmodule

// ===== logic/slc_engine.sv
// Softload command engine: query, download, copy and swap handling
module slc_engine
  import slc_pkg::*;
#(
  parameter int unsigned START_WAIT   = slc_pkg::START_WAIT_CYC,
  parameter int unsigned REINIT_WAIT  = slc_pkg::REINIT_CYC,
  parameter int unsigned G_GAP        = slc_pkg::G_GAP_CYC,
  parameter logic [31:0] PRODUCT_CODE = 32'h0000_1234
) (
  input  wire logic              clock_in,
  input  wire logic              rst_in,
  input  wire logic              clk_en_in,
  input  wire logic              feature_present_in,
  input  wire logic              other_port_busy_in,
  input  wire logic              cmd_valid_in,
  input  wire slc_pkg::slc_cmd_t cmd_op_in,
  input  wire logic              pw_match_in,
  input  wire logic              rx_valid_in,
  input  wire logic [7:0]        rx_byte_in,
  input  wire logic              frame_gap_in,
  input  wire logic              frame_seen_in,
  input  wire logic              xfer_done_in,
  input  wire logic              xfer_err_in,
  input  wire logic [7:0]        xfer_code_in,
  input  wire logic              flash_done_in,
  input  wire logic              flash_err_in,
  input  wire logic [7:0]        flash_code_in,
  input  wire logic              flash_busy_in,
  input  wire logic [7:0]        ver_set0_in,
  input  wire logic [7:0]        ver_set1_in,
  input  wire logic              nvm_sel_in,
  input  wire logic [1:0]        set_valid_in,
  input  wire logic              tx_ready_in,
  output logic                   msg_valid_out,
  output slc_pkg::slc_msg_t      msg_out,
  output logic [31:0]            product_code_out,
  output logic [7:0]             act_ver_out,
  output logic [7:0]             alt_ver_out,
  output logic                   act_invalid_out,
  output logic                   alt_invalid_out,
  output logic                   tx_valid_out,
  output logic [7:0]             tx_byte_out,
  output logic                   flow_hold_out,
  output logic                   flash_req_out,
  output slc_pkg::slc_fop_t      flash_op_out,
  output logic                   nvm_wr_out,
  output logic                   active_sel_out,
  output logic                   sys_reset_out,
  output logic                   busy_out,
  output logic [7:0]             result_code_out
);

  import slc_pkg::*;

  if (START_WAIT < 1 || REINIT_WAIT < 1 || START_WAIT >= 2 ** TMR_W
      || REINIT_WAIT >= 2 ** TMR_W || G_GAP < 1 || G_GAP > 2 ** GAP_W) begin : g_bad_param
    $error("slc_engine: timing parameter out of range");
  end

  typedef struct packed {
    slc_state_t       st;
    logic [GAP_W-1:0] gap;
    logic [3:0]       cans;
    logic [1:0]       host_can;
    logic             init_done;
    logic             act_sel;
    logic [1:0]       valid;
    logic             msg_valid;
    slc_msg_t         msg;
    logic [31:0]      product;
    logic [7:0]       act_ver;
    logic [7:0]       alt_ver;
    logic             act_invalid;
    logic             alt_invalid;
    logic             tx_valid;
    logic [7:0]       tx_byte;
    logic             flow_hold;
    logic             flash_req;
    slc_fop_t         flash_op;
    logic             nvm_wr;
    logic             sys_reset;
    logic             busy;
    logic [7:0]       result;
  } slc_eng_t;

  slc_eng_t         s;
  slc_eng_t         n;
  logic             alt_sel;
  logic             t_load;
  logic             t_stop;
  logic [TMR_W-1:0] t_val;
  logic             t_exp;

  function automatic logic [7:0] ver_of(input logic sel, input logic [7:0] v0,
                                        input logic [7:0] v1);
    ver_of = sel ? v1 : v0;
  endfunction

  assign alt_sel = ~s.act_sel;

  slc_timer #(.WIDTH(TMR_W)) u_timer (
    .clock_in    (clock_in),
    .rst_in      (rst_in),
    .clk_en_in   (clk_en_in),
    .load_in     (t_load),
    .stop_in     (t_stop),
    .value_in    (t_val),
    .expired_out (t_exp)
  );

  // ----------------------------------------------------------------
  // Command sequencing
  // ----------------------------------------------------------------
  always_comb begin
    n = s;
    n.msg_valid = 1'b0;
    n.nvm_wr = 1'b0;
    n.product = PRODUCT_CODE;
    t_load = 1'b0;
    t_stop = 1'b0;
    t_val = TMR_W'(START_WAIT);
    if (s.tx_valid && tx_ready_in) begin
      n.tx_valid = 1'b0;
    end
    if (!s.init_done) begin
      n.init_done = 1'b1;
      n.act_sel = nvm_sel_in;
      n.valid = set_valid_in;
    end
    unique case (s.st)
      ST_IDLE: begin
        if (cmd_valid_in && s.init_done) begin
          n.msg_valid = 1'b1;
          n.msg = MSG_ERROR;
          if (!feature_present_in) begin
            n.msg = MSG_ERROR;
          end else if (cmd_op_in == CMD_QUERY) begin
            n.msg = MSG_VERSION;
          end else if (!pw_match_in) begin
            n.result = RES_BAD_PW;
          end else if (other_port_busy_in && cmd_op_in != CMD_SWAP) begin
            n.result = RES_OTHER_PORT;
          end else if (cmd_op_in == CMD_DOWNLOAD) begin
            n.msg = MSG_BANNER;
            n.st = ST_DL_ERASE;
            n.flash_req = 1'b1;
            n.flash_op = FOP_ERASE;
          end else if (cmd_op_in == CMD_COPY) begin
            n.msg_valid = 1'b0;
            n.st = ST_CP_ERASE;
            n.flash_req = 1'b1;
            n.flash_op = FOP_ERASE;
          end else if (!s.valid[alt_sel]) begin
            n.result = RES_ALT_BAD;
          end else begin
            n.msg_valid = 1'b0;
            n.st = ST_SW_CHECK;
            n.flash_req = 1'b1;
            n.flash_op = FOP_CHECK;
          end
        end
      end
      ST_DL_ERASE: begin
        if (flash_done_in) begin
          n.flash_req = 1'b0;
          n.msg_valid = 1'b1;
          if (flash_err_in) begin
            n.msg = MSG_ERROR;
            n.result = flash_code_in;
            n.valid[alt_sel] = 1'b0;
            n.st = ST_IDLE;
          end else begin
            n.msg = MSG_READY;
            n.st = ST_DL_WAIT_G;
            n.gap = '0;
            n.valid[alt_sel] = 1'b0;
            t_load = 1'b1;
          end
        end
      end
      ST_DL_WAIT_G: begin
        if (s.gap != '0) begin
          n.gap = s.gap - GAP_W'(1);
        end else if (!n.tx_valid) begin
          n.tx_valid = 1'b1;
          n.tx_byte = G_BYTE;
          n.gap = GAP_W'(G_GAP - 1);
        end
        if (frame_seen_in) begin
          t_stop = 1'b1;
          n.host_can = '0;
          n.st = ST_DL_XFER;
        end else if (t_exp) begin
          n.result = RES_START_TO;
          n.cans = CAN_SERIES;
          n.st = ST_DL_CANCEL;
        end
      end
      ST_DL_XFER: begin
        if (rx_valid_in && frame_gap_in) begin
          n.host_can = (rx_byte_in == CAN_BYTE) ? s.host_can + 2'h1 : 2'h0;
        end
        if (xfer_err_in) begin
          n.result = xfer_code_in;
          n.cans = CAN_SERIES;
          n.st = ST_DL_CANCEL;
        end else if (n.host_can >= HOST_CAN_MIN) begin
          n.result = RES_CAN_RX;
          n.cans = CAN_SERIES;
          n.st = ST_DL_CANCEL;
        end else if (xfer_done_in) begin
          n.st = ST_DL_VERIFY;
          n.flash_req = 1'b1;
          n.flash_op = FOP_VERIFY;
        end
      end
      ST_DL_VERIFY, ST_CP_VERIFY: begin
        if (flash_done_in) begin
          n.flash_req = 1'b0;
          n.msg_valid = 1'b1;
          n.st = ST_IDLE;
          n.msg = flash_err_in ? MSG_ERROR : MSG_OK;
          n.result = flash_err_in ? flash_code_in : RES_DONE;
          n.valid[alt_sel] = !flash_err_in;
        end
      end
      ST_DL_CANCEL: begin
        n.valid[alt_sel] = 1'b0;
        if (!n.tx_valid) begin
          if (s.cans != '0) begin
            n.tx_valid = 1'b1;
            n.tx_byte = CAN_BYTE;
            n.cans = s.cans - 4'h1;
          end else begin
            n.msg_valid = 1'b1;
            n.msg = MSG_ERROR;
            n.st = ST_IDLE;
          end
        end
      end
      ST_CP_ERASE, ST_CP_PROG: begin
        if (flash_done_in) begin
          n.flash_req = 1'b1;
          if (flash_err_in) begin
            n.flash_req = 1'b0;
            n.msg_valid = 1'b1;
            n.msg = MSG_ERROR;
            n.result = (s.st == ST_CP_PROG) ? RES_COPY_FAIL : flash_code_in;
            n.valid[alt_sel] = 1'b0;
            n.st = ST_IDLE;
          end else if (s.st == ST_CP_ERASE) begin
            n.flash_op = FOP_COPY;
            n.valid[alt_sel] = 1'b0;
            n.st = ST_CP_PROG;
          end else begin
            n.flash_op = FOP_VERIFY;
            n.st = ST_CP_VERIFY;
          end
        end
      end
      ST_SW_CHECK: begin
        if (flash_done_in) begin
          n.flash_req = 1'b0;
          n.msg_valid = 1'b1;
          if (flash_err_in) begin
            n.msg = MSG_ERROR;
            n.result = flash_code_in;
            n.valid[alt_sel] = 1'b0;
            n.st = ST_IDLE;
          end else begin
            n.msg = MSG_OK;
            n.act_sel = alt_sel;
            n.nvm_wr = 1'b1;
            n.sys_reset = 1'b1;
            n.result = RES_NONE;
            t_load = 1'b1;
            t_val = TMR_W'(REINIT_WAIT);
            n.st = ST_SW_REINIT;
          end
        end
      end
      ST_SW_REINIT: begin
        if (t_exp) begin
          n.sys_reset = 1'b0;
          n.st = ST_IDLE;
        end
      end
    endcase
    if (rx_valid_in && s.st != ST_DL_WAIT_G && s.st != ST_DL_XFER && !n.tx_valid) begin
      n.tx_valid = 1'b1;
      n.tx_byte = rx_byte_in;
    end
    n.act_ver = ver_of(n.act_sel, ver_set0_in, ver_set1_in);
    n.alt_ver = ver_of(~n.act_sel, ver_set0_in, ver_set1_in);
    n.act_invalid = !n.valid[n.act_sel];
    n.alt_invalid = !n.valid[~n.act_sel];
    n.flow_hold = (n.st == ST_DL_XFER) && flash_busy_in;
    n.busy = (n.st != ST_IDLE);
  end

  always_ff @(posedge clock_in or posedge rst_in) begin
    if (rst_in) begin
      s <= '0;
    end else if (clk_en_in) begin
      s <= n;
    end
  end

  assign msg_valid_out    = s.msg_valid;
  assign msg_out          = s.msg;
  assign product_code_out = s.product;
  assign act_ver_out      = s.act_ver;
  assign alt_ver_out      = s.alt_ver;
  assign act_invalid_out  = s.act_invalid;
  assign alt_invalid_out  = s.alt_invalid;
  assign tx_valid_out     = s.tx_valid;
  assign tx_byte_out      = s.tx_byte;
  assign flow_hold_out    = s.flow_hold;
  assign flash_req_out    = s.flash_req;
  assign flash_op_out     = s.flash_op;
  assign nvm_wr_out       = s.nvm_wr;
  assign active_sel_out   = s.act_sel;
  assign sys_reset_out    = s.sys_reset;
  assign busy_out         = s.busy;
  assign result_code_out  = s.result;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clock_in); endclocking
  default disable iff (rst_in);

  chk_query_reply: assert property (
    (clk_en_in && s.st == ST_IDLE && s.init_done && cmd_valid_in && feature_present_in
     && cmd_op_in == CMD_QUERY) |=> (msg_valid_out && msg_out == MSG_VERSION))
    else $error("query not answered with version");

  chk_no_feature: assert property (
    (clk_en_in && s.st == ST_IDLE && s.init_done && cmd_valid_in && !feature_present_in)
    |=> (msg_valid_out && msg_out == MSG_ERROR && !busy_out))
    else $error("missing feature not answered with error");

  chk_bad_password: assert property (
    (clk_en_in && s.st == ST_IDLE && s.init_done && cmd_valid_in && feature_present_in
     && cmd_op_in != CMD_QUERY && !pw_match_in)
    |=> (msg_out == MSG_ERROR && result_code_out == RES_BAD_PW && !flash_req_out))
    else $error("bad password not refused");

  chk_invalid_swap: assert property (
    (nvm_wr_out && msg_valid_out) |-> $past(!s.valid[~s.act_sel]) == 1'b0)
    else $error("invalid set made active");

  chk_ready_erase: assert property (
    (clk_en_in && s.st == ST_DL_ERASE && flash_done_in && !flash_err_in)
    |=> (msg_out == MSG_READY && s.st == ST_DL_WAIT_G))
    else $error("no ready after erase");

  chk_start_timeout: assert property (
    (clk_en_in && s.st == ST_DL_WAIT_G && t_exp && !frame_seen_in)
    |=> (s.st == ST_DL_CANCEL && result_code_out == RES_START_TO && alt_invalid_out))
    else $error("start timeout not handled");

  chk_cancel_bytes: assert property (
    (s.st == ST_DL_CANCEL && s.cans != '0 && tx_valid_out && clk_en_in && tx_ready_in)
    |=> (tx_valid_out && tx_byte_out == CAN_BYTE))
    else $error("cancel series broken");

  chk_flow_hold: assert property (
    (clk_en_in && n.st == ST_DL_XFER && flash_busy_in) |=> flow_hold_out)
    else $error("flow hold not raised");

  chk_verify_reply: assert property (
    ($past(s.st) == ST_DL_VERIFY && s.st == ST_IDLE) |->
    (msg_valid_out && (result_code_out == RES_DONE) == (msg_out == MSG_OK)))
    else $error("verify answer mismatch");

  chk_swap_commit: assert property (
    nvm_wr_out |-> (msg_valid_out && msg_out == MSG_OK && sys_reset_out
                    && active_sel_out != $past(active_sel_out)))
    else $error("swap commit incomplete");

endmodule

// ===== tb/slc_flash_model.sv
// Flash programmer model answering the engine's flash requests
module slc_flash_model
  import slc_pkg::*;
(
  input  wire logic              clock_in,
  input  wire logic              rst_in,
  input  wire logic              req_in,
  input  wire slc_pkg::slc_fop_t op_in,
  input  wire slc_pkg::slc_fop_t fail_op_in,
  input  wire logic [7:0]        fail_code_in,
  input  wire logic [3:0]        dly_in,
  input  wire logic              stall_in,
  output logic                   done_out,
  output logic                   err_out,
  output logic [7:0]             code_out,
  output logic                   busy_out
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [3:0] cnt_q;
  assign busy_out = req_in | stall_in;
  always_ff @(posedge clock_in or posedge rst_in) begin
    if (rst_in) begin
      cnt_q    <= 4'h0;
      done_out <= 1'b0;
      err_out  <= 1'b0;
      code_out <= 8'h00;
    end else if (req_in && !done_out && cnt_q == dly_in) begin
      cnt_q    <= 4'h0;
      done_out <= 1'b1;
      err_out  <= (op_in == fail_op_in);
      code_out <= fail_code_in;
    end else begin
      cnt_q    <= req_in ? cnt_q + 4'h1 : 4'h0;
      done_out <= 1'b0;
      err_out  <= 1'b0;
      // Code lines not valid outside done: keep them moving
      code_out <= ~code_out;
    end
  end
endmodule

// ===== tb/test_slc_engine.sv
// Self-checking bench of the softload command engine
module test_slc_engine;
  timeunit 1ns;
  timeprecision 1ns;
  import slc_pkg::*;
  logic clock_in, rst_in, clk_en_in, feature_present_in, other_port_busy_in;
  logic cmd_valid_in, pw_match_in, rx_valid_in, frame_gap_in, frame_seen_in;
  logic xfer_done_in, xfer_err_in, flash_done_in, flash_err_in, flash_busy_in;
  logic nvm_sel_in, tx_ready_in, stall;
  logic [7:0] rx_byte_in, xfer_code_in, flash_code_in, ver_set0_in, ver_set1_in;
  logic [7:0] fail_code;
  logic [7:0] last_tx = 8'h00;
  logic [1:0] set_valid_in;
  logic [3:0] dly;
  slc_cmd_t cmd_op_in;
  slc_fop_t fail_op;
  logic msg_valid_out, act_invalid_out, alt_invalid_out, tx_valid_out;
  logic flow_hold_out, flash_req_out, nvm_wr_out, active_sel_out;
  logic sys_reset_out, busy_out;
  slc_msg_t msg_out;
  slc_fop_t flash_op_out;
  logic [31:0] product_code_out;
  logic [7:0] act_ver_out, alt_ver_out, tx_byte_out, result_code_out;
  int mismatches, cmp_count, c0;
  int can_n = 0, g_n = 0, nvm_n = 0;

  slc_engine #(.START_WAIT(200), .REINIT_WAIT(50), .G_GAP(20),
    .PRODUCT_CODE(32'h0000_5a5a)) slc_engine_i (
    .clock_in, .rst_in, .clk_en_in, .feature_present_in, .other_port_busy_in,
    .cmd_valid_in, .cmd_op_in, .pw_match_in, .rx_valid_in, .rx_byte_in,
    .frame_gap_in, .frame_seen_in, .xfer_done_in, .xfer_err_in, .xfer_code_in,
    .flash_done_in, .flash_err_in, .flash_code_in, .flash_busy_in,
    .ver_set0_in, .ver_set1_in, .nvm_sel_in, .set_valid_in, .tx_ready_in,
    .msg_valid_out, .msg_out, .product_code_out, .act_ver_out, .alt_ver_out,
    .act_invalid_out, .alt_invalid_out, .tx_valid_out, .tx_byte_out,
    .flow_hold_out, .flash_req_out, .flash_op_out, .nvm_wr_out,
    .active_sel_out, .sys_reset_out, .busy_out, .result_code_out);

  slc_flash_model slc_flash_model_i (
    .clock_in, .rst_in, .req_in(flash_req_out), .op_in(flash_op_out),
    .fail_op_in(fail_op), .fail_code_in(fail_code), .dly_in(dly),
    .stall_in(stall), .done_out(flash_done_in), .err_out(flash_err_in),
    .code_out(flash_code_in), .busy_out(flash_busy_in));

  initial begin
    clock_in = 1'b0;
    forever #50 clock_in = ~clock_in;
  end

  // --------------------------------------------------------------
  // Byte and store monitor
  // --------------------------------------------------------------
  always @(posedge clock_in) begin
    if (tx_valid_out === 1'b1 && tx_ready_in === 1'b1) begin
      last_tx <= tx_byte_out;
      if (tx_byte_out === CAN_BYTE) can_n <= can_n + 1;
      if (tx_byte_out === G_BYTE) g_n <= g_n + 1;
    end
    if (nvm_wr_out === 1'b1) nvm_n <= nvm_n + 1;
  end

  task automatic check(input logic [47:0] seen, input logic [47:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      mismatches++;
      $display("[FAIL] %0t ns: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic close_out;
    $display("comparisons %0d mismatches %0d", cmp_count, mismatches);
    if (mismatches == 0 && cmp_count > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  // Wait for a message pulse (0) or for idle (1)
  task automatic wait_sig(input int sel);
    int n;
    n = 0;
    while ((sel == 0 ? msg_valid_out : ~busy_out) !== 1'b1) begin
      @(negedge clock_in);
      n++;
      if (n > 3000) begin
        mismatches++;
        close_out();
      end
    end
  endtask

  task automatic wait_msg(input slc_msg_t exp);
    wait_sig(0);
    check(msg_out, exp);
    @(negedge clock_in);
  endtask

  task automatic cmd(input slc_cmd_t op, input logic pw);
    wait_sig(1);
    cmd_valid_in = 1'b1;
    cmd_op_in = op;
    pw_match_in = pw;
    @(negedge clock_in);
    cmd_valid_in = 1'b0;
  endtask

  task automatic strobe(input logic [2:0] s, input logic [7:0] b);
    {rx_valid_in, frame_seen_in, xfer_done_in} = s;
    rx_byte_in = b;
    @(negedge clock_in);
    {rx_valid_in, frame_seen_in, xfer_done_in} = 3'b000;
    // Gap cycle keeps two strobes apart
    @(negedge clock_in);
  endtask

  task automatic dl_start;
    cmd(CMD_DOWNLOAD, 1'b1);
    wait_msg(MSG_BANNER);
    wait_msg(MSG_READY);
  endtask

  initial begin
    {rst_in, clk_en_in, feature_present_in, tx_ready_in} = 4'hf;
    {other_port_busy_in, cmd_valid_in, pw_match_in, rx_valid_in} = 4'h0;
    {frame_gap_in, frame_seen_in, xfer_done_in, xfer_err_in, stall} = 5'h0;
    {nvm_sel_in, set_valid_in} = 3'b011;
    cmd_op_in = CMD_QUERY;
    {rx_byte_in, xfer_code_in, fail_code} = 24'h0;
    {ver_set0_in, ver_set1_in, dly} = {16'h1d1b, 4'h2};
    fail_op = FOP_NONE;
    mismatches = 0;
    cmp_count = 0;
    repeat (2) @(negedge clock_in);
    rst_in = 1'b0;
    repeat (3) @(negedge clock_in);
    check(result_code_out, RES_NONE);
    cmd(CMD_QUERY, 1'b1);
    wait_msg(MSG_VERSION);
    check({product_code_out, act_ver_out, alt_ver_out}, 48'h5a5a_1d1b);
    for (int i = 1; i < 4; i++) begin
      cmd(slc_cmd_t'(i), 1'b0);
      check(flash_req_out, 1'b0);
      wait_msg(MSG_ERROR);
      check(result_code_out, RES_BAD_PW);
    end
    // Host side: one file, hardware pacing only
    dl_start();
    check(alt_invalid_out, 1'b1);
    c0 = g_n;
    repeat (45) @(negedge clock_in);
    check(g_n >= c0 + 2, 1'b1);
    strobe(3'b010, 8'h00);
    stall = 1'b1;
    repeat (3) @(negedge clock_in);
    check(flow_hold_out, 1'b1);
    stall = 1'b0;
    strobe(3'b100, 8'h13);
    strobe(3'b100, 8'h11);
    check({flow_hold_out, last_tx}, {1'b0, G_BYTE});
    strobe(3'b001, 8'h00);
    check(flash_op_out, FOP_VERIFY);
    wait_msg(MSG_OK);
    check({result_code_out, alt_invalid_out}, {RES_DONE, 1'b0});
    c0 = can_n;
    dl_start();
    wait_msg(MSG_ERROR);
    check(result_code_out, RES_START_TO);
    check(can_n - c0, 8);
    cmd(CMD_QUERY, 1'b1);
    wait_msg(MSG_VERSION);
    check(alt_invalid_out, 1'b1);
    strobe(3'b100, 8'h41);
    repeat (3) @(negedge clock_in);
    check(last_tx, 8'h41);
    dl_start();
    strobe(3'b010, 8'h00);
    // Host abort: two cancel bytes between frames
    frame_gap_in = 1'b1;
    strobe(3'b100, CAN_BYTE);
    strobe(3'b100, CAN_BYTE);
    wait_msg(MSG_ERROR);
    check(result_code_out, RES_CAN_RX);
    frame_gap_in = 1'b0;
    dl_start();
    strobe(3'b010, 8'h00);
    {xfer_err_in, xfer_code_in} = 9'h169;
    @(negedge clock_in);
    xfer_err_in = 1'b0;
    wait_msg(MSG_ERROR);
    check(result_code_out, 8'h69);
    cmd(CMD_SWAP, 1'b1);
    wait_msg(MSG_ERROR);
    check({result_code_out, active_sel_out}, {RES_ALT_BAD, 1'b0});
    dly = 4'h9;
    fail_code = 8'h71;
    for (int i = 0; i < 4; i++) begin
      other_port_busy_in = (i == 0);
      fail_op = i == 1 ? FOP_COPY : (i == 2 ? FOP_ERASE : FOP_NONE);
      cmd(CMD_COPY, 1'b1);
      wait_msg(i == 3 ? MSG_OK : MSG_ERROR);
      check(result_code_out, i == 0 ? 8'h79 : (i == 1 ? 8'h7a :
        (i == 2 ? 8'h71 : 8'h10)));
    end
    // Mid-run reset: result code is volatile
    rst_in = 1'b1;
    repeat (2) @(negedge clock_in);
    rst_in = 1'b0;
    repeat (2) @(negedge clock_in);
    check({result_code_out, alt_invalid_out}, {RES_NONE, 1'b0});
    c0 = nvm_n;
    cmd(CMD_SWAP, 1'b1);
    wait_msg(MSG_OK);
    check({nvm_n - c0, active_sel_out}, {32'd1, 1'b1});
    check({sys_reset_out, result_code_out}, {1'b1, RES_NONE});
    // Clock enable low freezes the reinit wait
    clk_en_in = 1'b0;
    repeat (60) @(negedge clock_in);
    check(sys_reset_out, 1'b1);
    clk_en_in = 1'b1;
    cmd(CMD_QUERY, 1'b1);
    wait_msg(MSG_VERSION);
    check({act_ver_out, alt_ver_out, sys_reset_out}, {16'h1b1d, 1'b0});
    feature_present_in = 1'b0;
    cmd(CMD_QUERY, 1'b1);
    wait_msg(MSG_ERROR);
    close_out();
  end
endmodule
